// ---- pkg/wse_pkg.sv ----
// shared offsets, field positions and reset values of the wake/sysmgmt logic
package wse_pkg;
  // register offsets
  localparam logic [7:0] OFF_PM_CONTROL_TWO = 8'h61;
  localparam logic [7:0] OFF_SYSMGMT_STATUS7 = 8'h64;
  localparam logic [7:0] OFF_SYSMGMT_ENABLE7 = 8'h66;
  localparam logic [7:0] OFF_WAKE_STATUS7 = 8'h68;
  localparam logic [7:0] OFF_WAKE_ENABLE7 = 8'h6C;
  localparam logic [7:0] OFF_SYSMGMT_ENABLE2 = 8'h70;
  localparam logic [7:0] OFF_EVENT_CONFIG = 8'h71;
  localparam logic [7:0] OFF_EDGE_CONFIG = 8'h72;
  localparam logic [7:0] OFF_WAKE_STATUS4 = 8'h74;
  localparam logic [7:0] OFF_SYSMGMT_STATUS4 = 8'h75;
  localparam logic [7:0] OFF_PIN_CONTROL = 8'h76;
  localparam logic [7:0] OFF_PIN_TYPE = 8'h77;
  localparam logic [7:0] OFF_GPIO33_DATA = 8'h79;
  // field positions
  localparam int TRAP_BIT = 5;
  localparam int KBD_BIT = 4;
  localparam int SMI_OUT_EN_BIT = 7;
  localparam int WAKE_GLOBAL_BIT = 0;
  localparam int SMI_OD_BIT = 1;
  localparam int BANK4_PIN33_BIT = 3;
  localparam int PM2_RW_LO = 2;
  localparam int PM2_RW_HI = 4;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [5:0] RST_SMI_STATUS = 6'h00;
  localparam logic [3:0] RST_WAKE_STATUS = 4'h0;
  localparam logic [3:0] RST_PIN_NIBBLE = 4'h0;
endpackage : wse_pkg

// ---- pkg/wse_edge_if.sv ----
// edge detector controls and results passed between the event modules
`timescale 1ns/1ns
interface wse_edge_if #(
  parameter int N = 4
);
  logic [N-1:0] invert;
  logic [N-1:0] eitherEdge;
  logic [N-1:0] eventPulse;
  logic [N-1:0] level;
  modport det (input invert, input eitherEdge, output eventPulse,
    output level);
  modport ctl (output invert, output eitherEdge, input eventPulse,
    input level);
endinterface : wse_edge_if

// ---- hw/wse_edge_detect.sv ----
// pin synchroniser and polarity/either-edge event detector
`timescale 1ns/1ns
module wse_edge_detect #(
  parameter int N = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [N-1:0] pinAsync,
  wse_edge_if.det edges
);
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] prev_r;
  logic [N-1:0] eventPulse_nxt;

  // two flops before any logic looks at the pins
  always_ff @(posedge clock) begin
    sync1_r <= pinAsync;
    sync2_r <= sync1_r;
    prev_r <= sync2_r;
  end

  // polarity is applied to both samples, so flipping it makes no edge
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (edges.eitherEdge[i]) begin
        eventPulse_nxt[i] = sync2_r[i] ^ prev_r[i];
      end else begin
        eventPulse_nxt[i] = (sync2_r[i] ^ edges.invert[i]) &
          ~(prev_r[i] ^ edges.invert[i]);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      edges.eventPulse <= '0;
    end else begin
      edges.eventPulse <= eventPulse_nxt;
    end
  end

  assign edges.level = sync2_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_either_edge: assert property (
    (edges.eitherEdge[0] && $changed(sync2_r[0])) |=> edges.eventPulse[0])
    else $error("either-edge pin change gave no event");
  a_polarity_free: assert property (
    (edges.eitherEdge[0] && $stable(sync2_r[0])) |=> !edges.eventPulse[0])
    else $error("either-edge event without pin change");
endmodule : wse_edge_detect

// ---- hw/wse_event_logic.sv ----
// wake and system-management event collection for pins 34-37 and sleep trap
`timescale 1ns/1ns
module wse_event_logic (
  input wire logic clock,
  input wire logic srst,
  input wire logic mainResetPin,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdata,
  input wire logic [3:0] gpioIn,
  output logic [3:0] gpioOut,
  output logic [3:0] gpioOeN,
  input wire logic kbdPort1Bit6,
  input wire logic fddModeBit6,
  input wire logic fddModeBit7,
  input wire logic [3:0] fdcFuncData,
  output logic sysmgmtIrqOut,
  output logic sysmgmtIrqOeN,
  output logic wakeEventN,
  output logic irq,
  output logic gpio33Data
);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [2:0] pmCtl2_r;
  logic [5:0] smiSts_r;
  logic [5:0] smiEn_r;
  logic [3:0] wakeSts_r;
  logic [3:0] wakeEn_r;
  logic smiOutEn_r;
  logic wakeGlobalEn_r;
  logic smiOpenDrain_r;
  logic [3:0] eitherEdge_r;
  logic [3:0] invert_r;
  logic wakeSts4Bit3_r;
  logic smiSts4Bit3_r;
  logic [3:0] pinDirIn_r;
  logic [3:0] pinData_r;
  logic [3:0] fdcSel_r;
  logic [3:0] pinOpenDrain_r;
  logic mrSync1_r;
  logic mrSync2_r;
  logic kbdPrev_r;
  logic [5:0] smiSet;
  logic [5:0] smiClr;
  logic [3:0] wakeClr;
  logic trapWrite;
  logic mainRst;
  logic [3:0] pinDat;
  logic [3:0] pinOd;

  // write hit on one register offset
  function automatic logic hit(input logic [7:0] off);
    hit = busWr && (busAddr == off);
  endfunction : hit

  wse_edge_if #(.N(4)) edges ();

  wse_edge_detect #(.N(4)) u_edge (
    .clock(clock),
    .srst(srst),
    .pinAsync(gpioIn),
    .edges(edges.ctl)
  );

  assign edges.invert = invert_r;
  assign edges.eitherEdge = eitherEdge_r;

  ////////////////////////////////////////////////////////////////////////////
  // main-supply / hard reset arrives from a pin, so it is synchronised
  always_ff @(posedge clock) begin
    mrSync1_r <= mainResetPin;
    mrSync2_r <= mrSync1_r;
    kbdPrev_r <= kbdPort1Bit6;
  end
  assign mainRst = mrSync2_r;

  ////////////////////////////////////////////////////////////////////////////
  // event sources and write-one clears
  assign trapWrite = hit(wse_pkg::OFF_PM_CONTROL_TWO) &&
    busWdata[wse_pkg::TRAP_BIT];
  assign smiSet = {trapWrite, kbdPort1Bit6 & ~kbdPrev_r,
    edges.eventPulse};
  assign smiClr = hit(wse_pkg::OFF_SYSMGMT_STATUS7) ?
    busWdata[5:0] : 6'h00;
  assign wakeClr = hit(wse_pkg::OFF_WAKE_STATUS7) ?
    busWdata[3:0] : 4'h0;

  // set wins over clear so no event is lost in the clearing cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      smiSts_r <= wse_pkg::RST_SMI_STATUS;
    end else begin
      smiSts_r <= (smiSts_r & ~smiClr) | smiSet;
    end
  end

  // wake status sees only standby reset; main reset leaves it alone
  always_ff @(posedge clock) begin
    if (srst) begin
      wakeSts_r <= wse_pkg::RST_WAKE_STATUS;
    end else begin
      wakeSts_r <= (wakeSts_r & ~wakeClr) | edges.eventPulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read/write configuration registers
  always_ff @(posedge clock) begin
    if (srst) begin
      pmCtl2_r <= 3'h0;
      smiEn_r <= 6'h00;
      wakeEn_r <= 4'h0;
      smiOutEn_r <= 1'b0;
      wakeGlobalEn_r <= 1'b0;
      smiOpenDrain_r <= 1'b0;
      eitherEdge_r <= 4'h0;
      invert_r <= 4'h0;
      fdcSel_r <= 4'h0;
      pinOpenDrain_r <= 4'h0;
    end else begin
      if (hit(wse_pkg::OFF_PM_CONTROL_TWO)) begin
        pmCtl2_r <= busWdata[wse_pkg::PM2_RW_HI:wse_pkg::PM2_RW_LO];
      end
      if (hit(wse_pkg::OFF_SYSMGMT_ENABLE7)) begin
        smiEn_r <= busWdata[5:0];
      end
      if (hit(wse_pkg::OFF_WAKE_ENABLE7)) begin
        wakeEn_r <= busWdata[3:0];
      end
      if (hit(wse_pkg::OFF_SYSMGMT_ENABLE2)) begin
        smiOutEn_r <= busWdata[wse_pkg::SMI_OUT_EN_BIT];
      end
      if (hit(wse_pkg::OFF_EVENT_CONFIG)) begin
        wakeGlobalEn_r <= busWdata[wse_pkg::WAKE_GLOBAL_BIT];
        smiOpenDrain_r <= busWdata[wse_pkg::SMI_OD_BIT];
      end
      if (hit(wse_pkg::OFF_EDGE_CONFIG)) begin
        eitherEdge_r <= busWdata[3:0];
        invert_r <= busWdata[7:4];
      end
      if (hit(wse_pkg::OFF_PIN_TYPE)) begin
        fdcSel_r <= busWdata[3:0];
        pinOpenDrain_r <= busWdata[7:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank4 bit3, pin 33 and pin direction are restored by main reset too
  always_ff @(posedge clock) begin
    if (srst || mainRst) begin
      wakeSts4Bit3_r <= 1'b1;
      smiSts4Bit3_r <= 1'b1;
      gpio33Data <= 1'b1;
      pinDirIn_r <= wse_pkg::RST_PIN_NIBBLE;
      pinData_r <= wse_pkg::RST_PIN_NIBBLE;
    end else begin
      // pin 33 is never a wake source, so these bits only clear
      if (hit(wse_pkg::OFF_WAKE_STATUS4) &&
          busWdata[wse_pkg::BANK4_PIN33_BIT]) begin
        wakeSts4Bit3_r <= 1'b0;
      end
      if (hit(wse_pkg::OFF_SYSMGMT_STATUS4) &&
          busWdata[wse_pkg::BANK4_PIN33_BIT]) begin
        smiSts4Bit3_r <= 1'b0;
      end
      if (hit(wse_pkg::OFF_GPIO33_DATA)) begin
        gpio33Data <= busWdata[0];
      end
      if (hit(wse_pkg::OFF_PIN_CONTROL)) begin
        pinDirIn_r <= busWdata[3:0];
        pinData_r <= busWdata[7:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin source: floppy function takes data and output type from its mode
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pinDat[i] = fdcSel_r[i] ? (fdcFuncData[i] ^ fddModeBit7) :
        pinData_r[i];
      pinOd[i] = fdcSel_r[i] ? fddModeBit6 : pinOpenDrain_r[i];
    end
  end

  // pin drivers; main reset forces low outputs even with floppy selected,
  // since the floppy select itself survives main reset
  always_ff @(posedge clock) begin
    if (srst || mainRst) begin
      gpioOut <= 4'h0;
      gpioOeN <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        gpioOut[i] <= pinDat[i];
        // open-drain lets go of a one instead of driving it
        gpioOeN[i] <= (pinDirIn_r[i] && !fdcSel_r[i]) ||
          (pinOd[i] && pinDat[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // group interrupt, sysmgmt pin and wake pin, all registered
  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
      sysmgmtIrqOut <= 1'b1;
      sysmgmtIrqOeN <= 1'b1;
      wakeEventN <= 1'b1;
    end else begin
      irq <= |(smiSts_r & smiEn_r);
      // active low; idle floats when open-drain, drives high otherwise
      if ((|(smiSts_r & smiEn_r)) && smiOutEn_r) begin
        sysmgmtIrqOut <= 1'b0;
        sysmgmtIrqOeN <= 1'b0;
      end else begin
        sysmgmtIrqOut <= 1'b1;
        sysmgmtIrqOeN <= smiOpenDrain_r;
      end
      wakeEventN <= !(wakeGlobalEn_r && |(wakeSts_r & wakeEn_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clock) begin
    if (srst) begin
      busRdata <= wse_pkg::RST_ZERO;
    end else if (busRd) begin
      unique case (busAddr)
        wse_pkg::OFF_PM_CONTROL_TWO: busRdata <= {3'h0, pmCtl2_r, 2'h0};
        wse_pkg::OFF_SYSMGMT_STATUS7: busRdata <= {2'h0, smiSts_r};
        wse_pkg::OFF_SYSMGMT_ENABLE7: busRdata <= {2'h0, smiEn_r};
        wse_pkg::OFF_WAKE_STATUS7: busRdata <= {4'h0, wakeSts_r};
        wse_pkg::OFF_WAKE_ENABLE7: busRdata <= {4'h0, wakeEn_r};
        wse_pkg::OFF_SYSMGMT_ENABLE2: busRdata <= {smiOutEn_r, 7'h00};
        wse_pkg::OFF_EVENT_CONFIG:
          busRdata <= {6'h00, smiOpenDrain_r, wakeGlobalEn_r};
        wse_pkg::OFF_EDGE_CONFIG: busRdata <= {invert_r, eitherEdge_r};
        wse_pkg::OFF_WAKE_STATUS4: busRdata <= {4'h0, wakeSts4Bit3_r, 3'h0};
        wse_pkg::OFF_SYSMGMT_STATUS4: busRdata <= {4'h0, smiSts4Bit3_r, 3'h0};
        wse_pkg::OFF_PIN_CONTROL: busRdata <= {pinData_r, pinDirIn_r};
        wse_pkg::OFF_PIN_TYPE: busRdata <= {pinOpenDrain_r, fdcSel_r};
        wse_pkg::OFF_GPIO33_DATA: busRdata <= {7'h00, gpio33Data};
        default: busRdata <= wse_pkg::RST_ZERO;
      endcase
    end else begin
      busRdata <= wse_pkg::RST_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_smi_set_sticky: assert property (
    |smiSet |=> ((smiSts_r & $past(smiSet)) == $past(smiSet)))
    else $error("sysmgmt event not latched");
  a_trap_sets_bit: assert property (
    trapWrite |=> smiSts_r[5] ##1 (irq || !$past(smiEn_r[5])))
    else $error("trap write did not set status");
  a_group_gating: assert property (
    (smiEn_r == 6'h00) [*2] |-> !irq)
    else $error("group irq with all sources disabled");
  a_wake_free_run: assert property (
    (edges.eventPulse[0] && !wakeEn_r[0]) |=> wakeSts_r[0])
    else $error("wake status gated by enable");
  a_wake_hold: assert property (
    (wakeSts_r[0] && !wakeClr[0]) |=> wakeSts_r[0])
    else $error("wake status dropped without clear");
  a_wake_no_mainrst: assert property (
    (mainRst && wakeSts_r[0] && !wakeClr[0]) |=> wakeSts_r[0])
    else $error("main reset touched wake status");
  a_wake_zero_write: assert property (
    (hit(wse_pkg::OFF_WAKE_STATUS7) && busWdata == 8'h00) |=>
      ((wakeSts_r & $past(wakeSts_r)) == $past(wakeSts_r)))
    else $error("zero write cleared wake status");
  a_wake_pin_on: assert property (
    (wakeGlobalEn_r && |(wakeSts_r & wakeEn_r)) |=> !wakeEventN)
    else $error("wake pin not asserted");
  a_wake_pin_off: assert property (
    (wakeEn_r == 4'h0) |=> wakeEventN)
    else $error("wake pin asserted with no enables");
  a_pins_low_out: assert property (
    mainRst [*2] |-> (gpioOut == 4'h0 && gpioOeN == 4'h0) || !$past(mainRst))
    else $error("main reset left pins not driving low");
  a_smi_pin_idle: assert property (
    !smiOutEn_r |=> sysmgmtIrqOut)
    else $error("sysmgmt pin active while disabled");
  a_smi_pin_od: assert property (
    (!smiOutEn_r && smiOpenDrain_r) |=> sysmgmtIrqOeN)
    else $error("open-drain idle pin driven");
  a_bank4_set: assert property (
    mainRst |=> (wakeSts4Bit3_r && smiSts4Bit3_r && gpio33Data))
    else $error("main reset did not set pin33 bits");
  a_fdd_override: assert property (
    (fdcSel_r[0] && !pinDirIn_r[0] && !fddModeBit6 && !mainRst) |=>
      !gpioOeN[0])
    else $error("floppy push-pull not honoured");
  a_trap_reads_zero: assert property (
    busRd |=> !busRdata[wse_pkg::TRAP_BIT] || $past(busAddr) !=
      wse_pkg::OFF_PM_CONTROL_TWO)
    else $error("write-only trap bit read back");
  a_irq_follows: assert property (
    (|(smiSts_r & smiEn_r)) |=> irq)
    else $error("group irq missing");
  a_kbd_edge_sets: assert property (
    (kbdPort1Bit6 && !kbdPrev_r) |=> smiSts_r[4])
    else $error("kbd bit edge not latched");
  a_rdata_idle_zero: assert property (
    !$past(busRd) |-> busRdata == 8'h00)
    else $error("read data outside its cycle");

  c_trap_irq: cover property (trapWrite ##2 irq);
  c_wake_pin: cover property (edges.eventPulse[3] ##[1:4] !wakeEventN);
  c_set_clear_clash: cover property (|(smiSet & smiClr));
  c_smi_pin_active: cover property (!sysmgmtIrqOut && !sysmgmtIrqOeN);
  c_pin_high_latched: cover property (edges.level[0] && wakeSts_r[0]);
endmodule : wse_event_logic

// ---- dv/wse_host_model.sv ----
// host-side model: resolves the sysmgmt irq line and counts wake requests
`timescale 1ns/1ns
module wse_host_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic sysmgmtIrqOut,
  input wire logic sysmgmtIrqOeN,
  input wire logic wakeEventN,
  output logic smiLevel,
  output logic [7:0] wakeCnt_r
);
  logic wakeSeen_r;

  ////////////////////////////////////////////////////////////////////////////
  // board pull-up holds the line high once the buffer lets go, so an idle
  // open-drain pin never shows a stale driven value
  assign smiLevel = sysmgmtIrqOeN ? 1'b1 : sysmgmtIrqOut;

  ////////////////////////////////////////////////////////////////////////////
  // count each new wake request; a held level counts once only
  always_ff @(posedge clock) begin
    if (srst) begin
      wakeSeen_r <= 1'b0;
      wakeCnt_r <= 8'h00;
    end else begin
      wakeSeen_r <= ~wakeEventN;
      if (~wakeEventN && !wakeSeen_r) begin
        wakeCnt_r <= wakeCnt_r + 8'h01;
      end
    end
  end
endmodule : wse_host_model

// ---- dv/tb.sv ----
// self-checking bench of the wake and sysmgmt event logic
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
  end end
module tb;
  logic clock, srst, mainResetPin, busWr, busRd, kbdPort1Bit6;
  logic fddModeBit6, fddModeBit7, sysmgmtIrqOut, sysmgmtIrqOeN;
  logic wakeEventN, irq, gpio33Data, smiLevel;
  logic [7:0] busAddr, busWdata, busRdata, wakeCnt;
  logic [3:0] gpioIn, gpioOut, gpioOeN, fdcFuncData;
  logic [23:0] rows [6];
  int error_cnt = 0;
  int num_checks = 0;
  int cycleCnt = 0;

  wse_event_logic i_wse_event_logic (.clock(clock), .srst(srst),
    .mainResetPin(mainResetPin), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOeN(gpioOeN), .kbdPort1Bit6(kbdPort1Bit6),
    .fddModeBit6(fddModeBit6), .fddModeBit7(fddModeBit7),
    .fdcFuncData(fdcFuncData), .sysmgmtIrqOut(sysmgmtIrqOut),
    .sysmgmtIrqOeN(sysmgmtIrqOeN), .wakeEventN(wakeEventN), .irq(irq),
    .gpio33Data(gpio33Data));
  wse_host_model i_wse_host_model (.clock(clock), .srst(srst),
    .sysmgmtIrqOut(sysmgmtIrqOut), .sysmgmtIrqOeN(sysmgmtIrqOeN),
    .wakeEventN(wakeEventN), .smiLevel(smiLevel), .wakeCnt_r(wakeCnt));

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run, shared by the main sequence and the watchdog
  task automatic results;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // watchdog: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycleCnt++;
    if (cycleCnt == 3000) begin
      error_cnt++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus master: strobes one cycle wide, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge clock);
    busWr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so look there
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clock);
    busRd <= 1'b0;
    #1;
    `CHK(busRdata, e)
  endtask : chk_rd

  // let n edges pass and sample once their updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    // address, write data, expected read back
    rows = '{24'h66FF3F, 24'h6CFF0F, 24'h613C1C, 24'hAAFF00, 24'h660000,
      24'h6C0000};
    srst = 1'b1;
    mainResetPin = 1'b0;
    busAddr = 8'h00;
    busWdata = 8'h00;
    busWr = 1'b0;
    busRd = 1'b0;
    gpioIn = 4'h0;
    kbdPort1Bit6 = 1'b0;
    fddModeBit6 = 1'b0;
    fddModeBit7 = 1'b0;
    fdcFuncData = 4'h0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK({wakeEventN, sysmgmtIrqOut, sysmgmtIrqOeN, irq}, 4'hE)
    `CHK({gpioOut, gpioOeN, 3'h0, gpio33Data}, 12'h001)
    chk_rd(8'h64, 8'h00);
    chk_rd(8'h68, 8'h00);
    chk_rd(8'h74, 8'h08);
    chk_rd(8'h75, 8'h08);
    // plain register cases; the 0x61 row also fires the sleep trap
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      chk_rd(rows[i][23:16], rows[i][7:0]);
    end
    chk_rd(8'h64, 8'h20);
    // trap routed to the irq pin, then gated, idled, masked, cleared
    wr(8'h66, 8'h20);
    wr(8'h70, 8'h80);
    wr(8'h71, 8'h01);
    step(2);
    `CHK({irq, sysmgmtIrqOut, sysmgmtIrqOeN}, 3'h4)
    wr(8'h70, 8'h00);
    step(2);
    `CHK({irq, sysmgmtIrqOut, sysmgmtIrqOeN}, 3'h6)
    wr(8'h71, 8'h03);
    step(2);
    `CHK({sysmgmtIrqOeN, smiLevel}, 2'h3)
    wr(8'h66, 8'h00);
    step(2);
    `CHK(irq, 1'h0)
    wr(8'h66, 8'h20);
    wr(8'h64, 8'h20);
    step(2);
    `CHK(irq, 1'h0)
    // pin 34 as input, rising edge with its wake enable still off
    wr(8'h76, 8'h0F);
    gpioIn <= 4'h1;
    step(6);
    chk_rd(8'h64, 8'h01);
    chk_rd(8'h68, 8'h01);
    `CHK(wakeEventN, 1'h1)
    wr(8'h6C, 8'h01);
    step(2);
    `CHK({wakeEventN, wakeCnt}, 9'h001)
    wr(8'h71, 8'h02);
    step(2);
    `CHK(wakeEventN, 1'h1)
    wr(8'h68, 8'h00);
    chk_rd(8'h68, 8'h01);
    // falling edge in normal mode must not count
    wr(8'h68, 8'h0F);
    wr(8'h64, 8'h3F);
    gpioIn <= 4'h0;
    step(6);
    chk_rd(8'h68, 8'h00);
    // either-edge with inversion set: both edges count, polarity ignored
    wr(8'h72, 8'h11);
    step(6);
    wr(8'h64, 8'h3F);
    wr(8'h68, 8'h0F);
    gpioIn <= 4'h1;
    step(6);
    chk_rd(8'h64, 8'h01);
    wr(8'h64, 8'h01);
    gpioIn <= 4'h0;
    step(6);
    chk_rd(8'h64, 8'h01);
    // keyboard port bit rising edge; pins made non-inverted push-pull outputs
    wr(8'h72, 8'h00);
    wr(8'h76, 8'h00);
    kbdPort1Bit6 <= 1'b1;
    step(4);
    chk_rd(8'h64, 8'h11);
    // main-supply reset keeps status, restores pins and bank4 bit 3
    wr(8'h74, 8'h08);
    wr(8'h79, 8'h00);
    chk_rd(8'h74, 8'h00);
    `CHK(gpio33Data, 1'h0)
    mainResetPin <= 1'b1;
    step(3);
    mainResetPin <= 1'b0;
    step(4);
    `CHK({gpioOut, gpioOeN, gpio33Data}, 9'h001)
    chk_rd(8'h76, 8'h00);
    chk_rd(8'h74, 8'h08);
    chk_rd(8'h68, 8'h01);
    chk_rd(8'h64, 8'h11);
    // floppy function on pin 34: mode bit 7 flips data, bit 6 sets type
    wr(8'h77, 8'h01);
    fdcFuncData <= 4'h1;
    fddModeBit7 <= 1'b1;
    step(3);
    `CHK(gpioOut[0], 1'h0)
    fddModeBit7 <= 1'b0;
    fddModeBit6 <= 1'b1;
    step(3);
    `CHK({gpioOut[0], gpioOeN[0]}, 2'h3)
    // of the two resets, only the standby reset clears the wake status
    srst <= 1'b1;
    step(2);
    srst <= 1'b0;
    chk_rd(8'h68, 8'h00);
    results();
  end
endmodule : tb
